// File: rtl/lhzj_consts.svh
// lhzj_consts.svh: named constants for the limit/hold/zone judge
// assumes: included by rtl files by bare name
`ifndef LHZJ_CONSTS_SVH
`define LHZJ_CONSTS_SVH
`define LHZJ_DATA_W 24
`define LHZJ_ZONES 5
`define LHZJ_TIME_W 24
`define LHZJ_RST_OFF 1'b0
`define LHZJ_HOLD_RST 24'h000000
`define LHZJ_MAX_INIT 24'h800000
`define LHZJ_MIN_INIT 24'h7fffff
`endif

// File: rtl/lhzj_pkg.sv
// lhzj_pkg: types for the limit/hold/zone judge
// assumes: nothing beyond the consts header
package lhzj_pkg;
  typedef enum logic [2:0] {
    LHZJ_HOLD_OFF = 3'b000,
    LHZJ_HOLD_SAMPLE = 3'b001,
    LHZJ_HOLD_PEAK = 3'b010,
    LHZJ_HOLD_BOTTOM = 3'b011,
    LHZJ_HOLD_SPAN = 3'b100
  } lhzj_hold_t;
  typedef enum logic [1:0] {
    LHZJ_ST_IDLE = 2'b00,
    LHZJ_ST_RUN = 2'b01
  } lhzj_state_t;
  typedef struct packed {
    logic lower_outer;
    logic lower;
    logic ok;
    logic upper;
    logic upper_outer;
  } lhzj_cont_t;
  typedef struct packed {
    logic start;
    logic stop;
    logic clear;
  } lhzj_ctl_t;
endpackage : lhzj_pkg

// File: rtl/lhzj_judge.sv
// lhzj_judge: continuous limit judgment, hold modes, band and zone judgment
// assumes: sample stream synchronous to ref_clk_i, one strobe per sample
`timescale 1ns/1ps
`include "lhzj_consts.svh"
module lhzj_judge #(
  parameter int DW = `LHZJ_DATA_W,
  parameter int NZ = `LHZJ_ZONES,
  parameter int TW = `LHZJ_TIME_W
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic sample_i,
  input wire logic signed [DW-1:0] load_i,
  input wire logic signed [DW-1:0] disp_i,
  input wire lhzj_pkg::lhzj_ctl_t ctl_i,
  input wire lhzj_pkg::lhzj_hold_t hold_mode_i,
  input wire logic signed [DW-1:0] lower_outer_limit_i,
  input wire logic signed [DW-1:0] lower_limit_i,
  input wire logic signed [DW-1:0] upper_limit_i,
  input wire logic signed [DW-1:0] upper_outer_limit_i,
  input wire logic outer_limits_on_i,
  input wire logic axis_disp_i,
  input wire logic band_enable_i,
  input wire logic ref_wave_valid_i,
  input wire logic signed [DW-1:0] band_upper_i,
  input wire logic signed [DW-1:0] band_lower_i,
  input wire logic [NZ-1:0] zone_enable_i,
  input wire logic [NZ*3-1:0] zone_hold_method_i,
  input wire logic [NZ*TW-1:0] zone_from_i,
  input wire logic [NZ*TW-1:0] zone_to_i,
  input wire logic [NZ*DW-1:0] zone_upper_i,
  input wire logic [NZ*DW-1:0] zone_lower_i,
  input wire logic [NZ*DW-1:0] zone_disp_upper_i,
  input wire logic [NZ*DW-1:0] zone_disp_lower_i,
  output lhzj_pkg::lhzj_cont_t cont_o,
  output logic recording_state_o,
  output logic holding_o,
  output logic signed [DW-1:0] analog_o,
  output logic signed [DW-1:0] held_o,
  output logic band_ok_o,
  output logic [NZ-1:0] zone_ok_o,
  output logic [NZ-1:0] zone_disp_ok_o,
  output logic zone_disp_valid_o,
  output logic load_ok_o
);
  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= `LHZJ_RST_OFF;
      rst_n <= `LHZJ_RST_OFF;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  lhzj_pkg::lhzj_state_t state;
  lhzj_pkg::lhzj_state_t next_state;
  wire hold_sel = (hold_mode_i != lhzj_pkg::LHZJ_HOLD_OFF);
  wire step = clk_en_i && sample_i;
  wire run = (state == lhzj_pkg::LHZJ_ST_RUN);
  wire meas_run = run && !hold_sel;
  wire hold_run = run && hold_sel;
  wire go = ctl_i.start && !run;
  wire halt = ctl_i.stop && run;

  always_comb begin
    next_state = state;
    case (state)
      lhzj_pkg::LHZJ_ST_IDLE: begin
        if (go) begin
          next_state = lhzj_pkg::LHZJ_ST_RUN;
        end
      end
      lhzj_pkg::LHZJ_ST_RUN: begin
        if (halt) begin
          next_state = lhzj_pkg::LHZJ_ST_IDLE;
        end
      end
      default: next_state = lhzj_pkg::LHZJ_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= lhzj_pkg::LHZJ_ST_IDLE;
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // sample capture
  // ----------------------------------------------------------------
  // the data lines only carry a valid word beside the strobe
  logic signed [DW-1:0] live;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      live <= `LHZJ_HOLD_RST;
    end else if (step) begin
      live <= load_i;
    end
  end

  // ----------------------------------------------------------------
  // continuous hold
  // ----------------------------------------------------------------
  logic signed [DW-1:0] hmax;
  logic signed [DW-1:0] hmin;
  logic signed [DW-1:0] hsmp;
  wire signed [DW-1:0] next_hmax = (load_i > hmax) ? load_i : hmax;
  wire signed [DW-1:0] next_hmin = (load_i < hmin) ? load_i : hmin;
  wire signed [DW-1:0] span = DW'(hmax - hmin);
  wire clr_hold = clk_en_i && ctl_i.clear && hold_run;
  wire signed [DW-1:0] cur = step ? load_i : live;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hmax <= `LHZJ_MAX_INIT;
      hmin <= `LHZJ_MIN_INIT;
      hsmp <= `LHZJ_HOLD_RST;
    end else if ((clk_en_i && go && hold_sel) || clr_hold) begin
      hmax <= cur;
      hmin <= cur;
      hsmp <= cur;
    end else if (step && hold_run) begin
      hmax <= next_hmax;
      hmin <= next_hmin;
    end
  end

  // ----------------------------------------------------------------
  // hold value select
  // ----------------------------------------------------------------
  logic signed [DW-1:0] hold_val;
  always_comb begin
    case (hold_mode_i)
      lhzj_pkg::LHZJ_HOLD_SAMPLE: hold_val = hsmp;
      lhzj_pkg::LHZJ_HOLD_PEAK: hold_val = hmax;
      lhzj_pkg::LHZJ_HOLD_BOTTOM: hold_val = hmin;
      lhzj_pkg::LHZJ_HOLD_SPAN: hold_val = span;
      default: hold_val = live;
    endcase
  end

  // ----------------------------------------------------------------
  // continuous limit judgment
  // ----------------------------------------------------------------
  wire cont_act = !run || hold_run;
  wire signed [DW-1:0] judged = hold_run ? hold_val : live;
  wire below_low = judged < lower_limit_i;
  wire above_high = judged > upper_limit_i;
  wire below_outer = outer_limits_on_i &&
    (judged < lower_outer_limit_i);
  wire above_outer = outer_limits_on_i &&
    (judged > upper_outer_limit_i);

  // ----------------------------------------------------------------
  // measurement timebase
  // ----------------------------------------------------------------
  logic [TW-1:0] t_cnt;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      t_cnt <= '0;
    end else if (clk_en_i && go) begin
      t_cnt <= '0;
    end else if (step && meas_run) begin
      t_cnt <= TW'(t_cnt + 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // band judgment
  // ----------------------------------------------------------------
  wire band_on = band_enable_i && ref_wave_valid_i && !hold_sel;
  wire band_in = (load_i <= band_upper_i) && (load_i >= band_lower_i);
  logic band_bad;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      band_bad <= 1'b0;
    end else if (clk_en_i && go) begin
      band_bad <= 1'b0;
    end else if (step && meas_run && band_on && !band_in) begin
      band_bad <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // zones, one generate loop
  // ----------------------------------------------------------------
  wire zones_on = !hold_sel;
  logic [NZ-1:0] zok;
  logic [NZ-1:0] zdok;
  genvar g;
  generate
    for (g = 0; g < NZ; g++) begin : g_zone
      wire [2:0] meth = zone_hold_method_i[g*3 +: 3];
      wire [TW-1:0] zf = zone_from_i[g*TW +: TW];
      wire [TW-1:0] zt = zone_to_i[g*TW +: TW];
      wire signed [DW-1:0] zu = zone_upper_i[g*DW +: DW];
      wire signed [DW-1:0] zl = zone_lower_i[g*DW +: DW];
      wire signed [DW-1:0] zdu = zone_disp_upper_i[g*DW +: DW];
      wire signed [DW-1:0] zdl = zone_disp_lower_i[g*DW +: DW];
      wire signed [DW-1:0] dpos = disp_i;
      wire in_t = (t_cnt >= zf) && (t_cnt <= zt);
      wire in_d = (dpos >= signed'(DW'(zf))) && (dpos <= signed'(DW'(zt)));
      wire in_z = axis_disp_i ? in_d : in_t;
      logic signed [DW-1:0] zmax;
      logic signed [DW-1:0] zmin;
      logic signed [DW-1:0] zsmp;
      logic signed [DW-1:0] zdmx;
      logic signed [DW-1:0] zdmn;
      logic signed [DW-1:0] zdsm;
      logic seen;
      wire upd = step && meas_run && zones_on && zone_enable_i[g] && in_z;
      always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          zmax <= `LHZJ_MAX_INIT;
          zmin <= `LHZJ_MIN_INIT;
          zsmp <= `LHZJ_HOLD_RST;
          zdmx <= `LHZJ_HOLD_RST;
          zdmn <= `LHZJ_HOLD_RST;
          zdsm <= `LHZJ_HOLD_RST;
          seen <= 1'b0;
        end else if (clk_en_i && go) begin
          zmax <= `LHZJ_MAX_INIT;
          zmin <= `LHZJ_MIN_INIT;
          seen <= 1'b0;
        end else if (upd) begin
          if (!seen || load_i > zmax) begin
            zmax <= load_i;
            zdmx <= dpos;
          end
          if (!seen || load_i < zmin) begin
            zmin <= load_i;
            zdmn <= dpos;
          end
          if (!seen) begin
            zsmp <= load_i;
            zdsm <= dpos;
          end
          seen <= 1'b1;
        end
      end
      logic signed [DW-1:0] zval;
      always_comb begin
        case (meth)
          3'h1: zval = zsmp;
          3'h2: zval = zmax;
          3'h3: zval = zmin;
          3'h4: zval = DW'(zmax - zmin);
          default: zval = live;
        endcase
      end
      assign zok[g] = !zone_enable_i[g] ||
        (seen && zval <= zu && zval >= zl);
      // position of the hold point; live and span have none
      logic signed [DW-1:0] zdval;
      logic zdhas;
      always_comb begin
        zdhas = 1'b1;
        case (meth)
          3'h1: zdval = zdsm;
          3'h2: zdval = zdmx;
          3'h3: zdval = zdmn;
          default: begin
            zdval = dpos;
            zdhas = 1'b0;
          end
        endcase
      end
      assign zdok[g] = !zone_enable_i[g] ||
        (seen && zdhas && zdval <= zdu && zdval >= zdl);
    end
  endgenerate

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  wire any_zone = |zone_enable_i;
  wire zones_ok = &zok;
  wire next_load_ok = zones_on && zones_ok &&
    (!band_on || !band_bad) && (any_zone || band_on);
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cont_o <= '0;
      recording_state_o <= 1'b0;
      holding_o <= 1'b0;
      band_ok_o <= 1'b0;
      zone_ok_o <= '0;
      zone_disp_ok_o <= '0;
      zone_disp_valid_o <= 1'b0;
      load_ok_o <= 1'b0;
    end else if (clk_en_i) begin
      cont_o.lower_outer <= cont_act && below_outer;
      cont_o.lower <= cont_act && below_low;
      cont_o.upper <= cont_act && above_high;
      cont_o.upper_outer <= cont_act && above_outer;
      cont_o.ok <= cont_act && !below_low && !above_high && !below_outer &&
        !above_outer;
      recording_state_o <= meas_run;
      holding_o <= hold_run;
      band_ok_o <= band_on && !band_bad;
      zone_ok_o <= zones_on ? (zok & zone_enable_i) : '0;
      zone_disp_ok_o <= (zones_on && axis_disp_i) ?
        (zdok & zone_enable_i) : '0;
      zone_disp_valid_o <= zones_on && axis_disp_i;
      load_ok_o <= next_load_ok;
    end
  end

  // ----------------------------------------------------------------
  // held and analog values
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      analog_o <= `LHZJ_HOLD_RST;
      held_o <= `LHZJ_HOLD_RST;
    end else if (clk_en_i) begin
      analog_o <= hold_run ? hold_val : live;
      held_o <= hold_val;
    end
  end
endmodule : lhzj_judge

// File: dv/lhzj_judge_assertions.sv
// lhzj_judge_assertions: port checks for lhzj_judge
// assumes: bound to every lhzj_judge instance
`timescale 1ns/1ps
module lhzj_judge_chk #(
  parameter int DW = 24,
  parameter int NZ = 5
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire lhzj_pkg::lhzj_ctl_t ctl_i,
  input wire lhzj_pkg::lhzj_hold_t hold_mode_i,
  input wire logic [NZ-1:0] zone_enable_i,
  input wire logic recording_state_o,
  input wire logic holding_o,
  input wire logic signed [DW-1:0] analog_o,
  input wire logic signed [DW-1:0] held_o,
  input wire logic band_ok_o,
  input wire logic [NZ-1:0] zone_ok_o,
  input wire logic load_ok_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_SAMPLE_FROZEN: assert property (
    holding_o && $past(holding_o) && !$past(ctl_i.clear, 2) &&
    $past(hold_mode_i) == lhzj_pkg::LHZJ_HOLD_SAMPLE |-> $stable(held_o))
    else $error("sample hold moved");
  AST_PEAK_RISE: assert property (
    holding_o && $past(holding_o) && !$past(ctl_i.clear, 2) &&
    $past(hold_mode_i) == lhzj_pkg::LHZJ_HOLD_PEAK |-> held_o >= $past(held_o))
    else $error("peak hold fell");
  AST_BOTTOM_FALL: assert property (
    holding_o && $past(holding_o) && !$past(ctl_i.clear, 2) &&
    $past(hold_mode_i) == lhzj_pkg::LHZJ_HOLD_BOTTOM |-> held_o <= $past(held_o))
    else $error("bottom hold rose");
  AST_ZONE_REFUSED: assert property (
    $past(clk_en_i && hold_mode_i != lhzj_pkg::LHZJ_HOLD_OFF)
    |-> zone_ok_o == '0 && !band_ok_o)
    else $error("zone result during hold mode");
  AST_HOLD_START: assert property (
    $past(ctl_i.start && clk_en_i && !holding_o && !recording_state_o &&
    hold_mode_i != lhzj_pkg::LHZJ_HOLD_OFF) |-> ##1 holding_o)
    else $error("hold did not start");
  AST_HOLD_STOP: assert property (
    $past(ctl_i.stop && clk_en_i && holding_o) |-> ##1 !holding_o)
    else $error("hold did not stop");
  AST_ANALOG_HELD: assert property (
    holding_o && $past(holding_o) |-> analog_o == held_o)
    else $error("analog not held value");
  AST_ALL_ZONES: assert property (
    load_ok_o |-> &(zone_ok_o | ~$past(zone_enable_i)))
    else $error("overall ok with a failed zone");
endmodule : lhzj_judge_chk
bind lhzj_judge lhzj_judge_chk #(.DW(DW), .NZ(NZ)) u_chk (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
  .ctl_i(ctl_i), .hold_mode_i(hold_mode_i), .zone_enable_i(zone_enable_i),
  .recording_state_o(recording_state_o), .holding_o(holding_o),
  .analog_o(analog_o), .held_o(held_o), .band_ok_o(band_ok_o),
  .zone_ok_o(zone_ok_o), .load_ok_o(load_ok_o));

// File: dv/lhzj_src_model.sv
// lhzj_src_model: sensor sample source, one strobe every 4 clocks
// assumes: bench sets val_i between strobes
`timescale 1ns/1ps
module lhzj_src_model (
  input wire logic ref_clk_i,
  input wire logic signed [23:0] val_i,
  output logic sample_o = 1'b0,
  output logic signed [23:0] load_o = 24'h0
);
  logic [1:0] cnt = 2'h0;
  // off the strobe the data alternates between the inverse and a stale copy
  always_ff @(posedge ref_clk_i) begin
    cnt <= cnt + 2'h1;
    sample_o <= (cnt == 2'h3);
    load_o <= (cnt == 2'h3) ? val_i : ~load_o;
  end
endmodule : lhzj_src_model

// File: dv/tb.sv
// tb: self-checking bench for lhzj_judge
// assumes: lhzj_src_model supplies the sample stream
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic outer = 1'b0;
  logic band_en = 1'b0;
  logic ref_ok = 1'b0;
  logic smp, recording_state, hold, band_ok, load_ok, zdv;
  logic [4:0] zen = 5'h0;
  logic [4:0] zok, zdok;
  logic signed [23:0] val = 24'h0;
  logic signed [23:0] load, analog, held;
  // ascending limits -200 < -100 < 100 < 200
  logic signed [23:0] low_out = 24'hffff38;
  logic signed [23:0] low_lim = 24'hffff9c;
  logic signed [23:0] high_lim = 24'h64;
  logic signed [23:0] high_out = 24'hc8;
  logic axis = 1'b0;
  logic signed [23:0] bup = 24'h64;
  logic signed [23:0] blo = 24'h0;
  logic [14:0] zmeth = 15'h4688;
  logic [119:0] zfrom = {24'h6, 24'h6, 24'h1, 24'h1, 24'h1};
  logic [119:0] zto = {24'h8, 24'h8, 24'h2, 24'h2, 24'h2};
  logic [119:0] zup = {24'h14, 24'h64, 24'h3c, 24'h3c, 24'h3c};
  logic [119:0] zlo = {24'ha, 24'h50, 24'h28, 24'h28, 24'h28};
  logic signed [23:0] tv [5] = '{24'h0, 24'h96, 24'hffff6a, 24'hfa,
    24'hffff06};
  logic signed [23:0] sq [4] = '{24'ha, 24'hffffd8, 24'h3c, 24'h0};
  logic signed [23:0] hx [3] = '{24'h3c, 24'hffffd8, 24'h64};
  lhzj_pkg::lhzj_ctl_t ctl = '0;
  lhzj_pkg::lhzj_hold_t mode = lhzj_pkg::LHZJ_HOLD_OFF;
  lhzj_pkg::lhzj_cont_t cont;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  always #10 ref_clk = ~ref_clk;
  lhzj_src_model src (.ref_clk_i(ref_clk), .val_i(val), .sample_o(smp),
    .load_o(load));
  lhzj_judge dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .clk_en_i(1'b1), .sample_i(smp), .load_i(load), .disp_i(load),
    .ctl_i(ctl), .hold_mode_i(mode), .lower_outer_limit_i(low_out),
    .lower_limit_i(low_lim), .upper_limit_i(high_lim),
    .upper_outer_limit_i(high_out),
    .outer_limits_on_i(outer), .axis_disp_i(axis), .band_enable_i(band_en),
    .ref_wave_valid_i(ref_ok), .band_upper_i(bup), .band_lower_i(blo),
    .zone_enable_i(zen), .zone_hold_method_i(zmeth), .zone_from_i(zfrom),
    .zone_to_i(zto), .zone_upper_i(zup), .zone_lower_i(zlo),
    .zone_disp_upper_i(zup), .zone_disp_lower_i(zlo), .cont_o(cont),
    .recording_state_o(recording_state), .holding_o(hold), .analog_o(analog),
    .held_o(held), .band_ok_o(band_ok), .zone_ok_o(zok),
    .zone_disp_ok_o(zdok), .zone_disp_valid_o(zdv), .load_ok_o(load_ok));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic put(input logic signed [23:0] v);
    @(posedge ref_clk) val <= v;
    do @(negedge ref_clk); while (!(smp === 1'b1 && load === v));
    repeat (2) @(negedge ref_clk);
  endtask : put
  task automatic pulse(input lhzj_pkg::lhzj_ctl_t c);
    @(posedge ref_clk) ctl <= c;
    @(posedge ref_clk) ctl <= '0;
    repeat (2) @(negedge ref_clk);
  endtask : pulse
  task automatic zone_run(input logic [4:0] en);
    @(posedge ref_clk) zen <= en;
    put(24'h32);
    pulse(3'b100);
    chk(recording_state, 1'b1);
    chk(cont.ok, 1'b0);
    for (int i = 0; i < 10; i++) put(i < 4 ? 24'h32 : 24'h5a);
    pulse(3'b010);
  endtask : zone_run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    logic signed [23:0] v;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int k = 0; k < 10; k++) begin
      v = tv[k % 5];
      @(posedge ref_clk) outer <= (k > 4);
      put(v);
      chk(cont.ok, (v >= low_lim && v <= high_lim));
      chk(cont.upper_outer, (outer && v > high_out));
      chk(cont.lower_outer, (outer && v < low_out));
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk) mode <= lhzj_pkg::lhzj_hold_t'(k + 2);
      put(24'h0);
      pulse(3'b100);
      chk(hold, 1'b1);
      foreach (sq[i]) put(sq[i]);
      chk(held, hx[k]);
      chk(analog, hx[k]);
      pulse(3'b010);
      chk(hold, 1'b0);
    end
    @(posedge ref_clk) mode <= lhzj_pkg::LHZJ_HOLD_PEAK;
    put(24'h0);
    pulse(3'b100);
    put(24'h32);
    put(24'h1e);
    pulse(3'b001);
    put(24'h28);
    chk(held, 24'h28);
    pulse(3'b010);
    put(24'h5a);
    chk(held, 24'h28);
    chk(analog, 24'h5a);
    @(posedge ref_clk) mode <= lhzj_pkg::LHZJ_HOLD_SAMPLE;
    put(24'h21);
    pulse(3'b100);
    put(24'h46);
    chk(held, 24'h21);
    pulse(3'b010);
    put(24'h46);
    chk(analog, 24'h46);
    @(posedge ref_clk) mode <= lhzj_pkg::LHZJ_HOLD_OFF;
    band_en <= 1'b1;
    ref_ok <= 1'b1;
    zone_run(5'h1f);
    chk(zok, 5'h0e);
    chk(band_ok, 1'b1);
    chk(load_ok, 1'b0);
    @(posedge ref_clk) ref_ok <= 1'b0;
    zone_run(5'h0e);
    chk(band_ok, 1'b0);
    chk(load_ok, 1'b1);
    chk(zdv, 1'b0);
    @(posedge ref_clk) mode <= lhzj_pkg::LHZJ_HOLD_PEAK;
    put(24'h0);
    chk(zok, 5'h0);
    @(posedge ref_clk) mode <= lhzj_pkg::LHZJ_HOLD_OFF;
    axis <= 1'b1;
    zone_run(5'h0e);
    chk(zdv, 1'b1);
    chk(zok, 5'h0);
    chk(zdok, 5'h0);
    finish_test();
  end
endmodule : tb
